/* File: hdl/adct_regs.svh */
// register map, field positions, reset values and timing counts
// assumes byte-wide registers on a plain strobe port
`ifndef ADCT_REGS_SVH
`define ADCT_REGS_SVH

`define ADCT_OFS_RESL 8'h78
`define ADCT_OFS_RESH 8'h79
`define ADCT_OFS_CTLA 8'h7A
`define ADCT_OFS_CTLB 8'h7B
`define ADCT_OFS_MUXS 8'h7C
`define ADCT_OFS_DIDR 8'h7E

`define ADCT_A_EN 7
`define ADCT_A_START 6
`define ADCT_A_ATE 5
`define ADCT_A_FLAG 4
`define ADCT_A_IE 3
`define ADCT_B_COMPARATOR_MUX_ENABLE 6
`define ADCT_M_LEFT 5

`define ADCT_RST_BYTE 8'h00
`define ADCT_NORMAL_CYC 13
`define ADCT_FIRST_CYC 25

`endif

/* File: hdl/adct_pkg.sv */
// types shared by the converter control block
// assumes adct_regs.svh holds the numeric constants
package adct_pkg;

  typedef enum logic [2:0] {
    ADCT_TS_FREE = 3'h0,
    ADCT_TS_COMP = 3'h1,
    ADCT_TS_EXT0 = 3'h2,
    ADCT_TS_T0CA = 3'h3,
    ADCT_TS_T0OV = 3'h4,
    ADCT_TS_T1CB = 3'h5,
    ADCT_TS_T1OV = 3'h6,
    ADCT_TS_T1CP = 3'h7
  } adct_tsel_t;

  // gray order along off -> idle -> run
  typedef enum logic [1:0] {
    ADCT_OFF = 2'b00,
    ADCT_IDLE = 2'b01,
    ADCT_RUN = 2'b11
  } adct_cst_t;

endpackage

/* File: hdl/adct_clk_if.sv */
// carrier between the control core and the converter clock divider
// assumes one system clock for both ends
`timescale 1ns/100ps
`default_nettype none
interface adct_clk_if;
  logic run;
  logic [2:0] sel;
  logic tick;
  modport core (output run, output sel, input tick);
  modport div (input run, input sel, output tick);
endinterface
`default_nettype wire

/* File: hdl/adct_presc.sv */
// converter clock divider: one-cycle tick per converter clock period
// assumes sel may change at any time; counter restarts when stopped
`timescale 1ns/100ps
`default_nettype none
module adct_presc import adct_pkg::*; #(
  parameter int CW = 7
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  adct_clk_if.div ck
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } adct_div_t;

  adct_div_t st_q;
  adct_div_t st_d;

  // codes 000 and 001 both divide by two
  function automatic logic [CW-1:0] last_of(input logic [2:0] s);
    logic [CW-1:0] one;
    one = {{(CW-1){1'b0}}, 1'b1};
    if (s < 3'h2) begin
      last_of = one;
    end else begin
      last_of = (one << s) - one;
    end
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!ck.run) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= last_of(ck.sel)) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ck.tick = st_q.tick;

  // only judged while the divider keeps running at code 001
  a_div_gap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_q.tick && ck.run ##1 ck.run && ck.sel == 3'h1
    |-> !st_q.tick ##1 st_q.tick)
    else $error("divide by two tick spacing wrong");

endmodule
`default_nettype wire

/* File: hdl/adct_core.sv */
// converter control: triggers, timing, result hold, flags, pin masks
// assumes converter core delivers conv_data_i stable in the cycle before conv_sample_o, when the result is loaded
// Functional notes
// - auto trigger starts on selected flag edge
// - done flag set when result loaded
// - irq needs flag, enable, global enable
// - entering irq vector clears done flag
// - write one clears flag, zero keeps
// - converter clock divides by 2 to 128
// - low read freezes results until high read
// - left adjust places result bits high
// - right adjust places low eight bits low
// - mux feeds comparator only when converter off
// - trigger select ignored without auto trigger
// - switching to set source makes edge
// - switching to free running never triggers
// - trigger select decodes eight sources
// - disabled pin buffers read as zero
// - 13 cycles, first after enable 25
// - start reads one while running
// - clearing enable aborts conversion
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "adct_regs.svh"
module adct_core import adct_pkg::*; #(
  parameter int NORM_CYC = `ADCT_NORMAL_CYC,
  parameter int FIRST_CYC = `ADCT_FIRST_CYC,
  parameter int RES_W = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:1] trig_flags_i,
  input wire logic glob_irq_en_i,
  input wire logic irq_ack_i,
  input wire logic [RES_W-1:0] conv_data_i,
  input wire logic [7:0] port_pin_i,
  output logic conv_irq_o,
  output logic conv_enable_o,
  output logic conv_busy_o,
  output logic conv_sample_o,
  output logic [3:0] chan_sel_o,
  output logic comp_mux_sel_o,
  output logic [7:0] pin_buf_off_o,
  output logic [7:0] port_pin_o
);

  typedef struct packed {
    adct_cst_t cst;
    logic en;
    logic ate;
    logic ie;
    logic [2:0] presc;
    logic flag;
    logic left;
    logic [3:0] mux;
    logic comparator_mux_enable;
    adct_tsel_t tsel;
    logic [7:0] didr;
    logic first;
    logic [4:0] cnt;
    logic [RES_W-1:0] result;
    logic lock;
    logic trig_prev;
    logic prev_free;
    logic [7:0] rdata;
    logic irq;
    logic sample;
    logic busy;
    logic comp_mux;
    logic [7:0] pin;
  } adct_state_t;

  adct_state_t st_q;
  adct_state_t st_d;
  adct_clk_if ck ();

  adct_presc u_presc (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ck(ck)
  );

  function automatic logic [7:0] fmt_res(input logic [RES_W-1:0] r,
                                         input logic left,
                                         input logic high);
    if (left) begin
      fmt_res = high ? r[9:2] : {r[1:0], 6'h00};
    end else begin
      fmt_res = high ? {6'h00, r[9:8]} : r[7:0];
    end
  endfunction

  function automatic logic trig_level(input adct_tsel_t s,
                                      input logic [7:1] f,
                                      input logic done);
    unique case (s)
      ADCT_TS_FREE: trig_level = done;
      ADCT_TS_COMP: trig_level = f[1];
      ADCT_TS_EXT0: trig_level = f[2];
      ADCT_TS_T0CA: trig_level = f[3];
      ADCT_TS_T0OV: trig_level = f[4];
      ADCT_TS_T1CB: trig_level = f[5];
      ADCT_TS_T1OV: trig_level = f[6];
      ADCT_TS_T1CP: trig_level = f[7];
    endcase
  endfunction

  logic wr_a;
  logic rd_lo;
  logic rd_hi;
  logic trig_now;
  logic auto_edge;
  logic conv_fin;
  logic sw_start;
  logic [4:0] last_cnt;

  assign wr_a = reg_wr_i && reg_addr_i == `ADCT_OFS_CTLA;
  assign rd_lo = reg_rd_i && reg_addr_i == `ADCT_OFS_RESL;
  assign rd_hi = reg_rd_i && reg_addr_i == `ADCT_OFS_RESH;
  assign trig_now = trig_level(st_q.tsel, trig_flags_i, st_q.flag);
  assign last_cnt = st_q.first ? 5'(FIRST_CYC - 1) : 5'(NORM_CYC - 1);
  assign conv_fin = st_q.cst == ADCT_RUN && st_q.en && ck.tick &&
                    st_q.cnt == last_cnt;

  // a fresh switch into free running is masked, other switches count
  assign auto_edge = st_q.ate && trig_now && !st_q.trig_prev &&
                     !(st_q.tsel == ADCT_TS_FREE && !st_q.prev_free);
  assign sw_start = wr_a && reg_wdata_i[`ADCT_A_START];

  assign ck.run = st_q.en;
  assign ck.sel = st_q.presc;

  always_comb begin
    st_d = st_q;
    st_d.sample = 1'b0;
    st_d.rdata = `ADCT_RST_BYTE;
    st_d.trig_prev = trig_now;
    st_d.prev_free = st_q.tsel == ADCT_TS_FREE;

    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `ADCT_OFS_CTLA: begin
          st_d.en = reg_wdata_i[`ADCT_A_EN];
          if (!st_q.en && reg_wdata_i[`ADCT_A_EN]) begin
            st_d.first = 1'b1;
          end
          st_d.ate = reg_wdata_i[`ADCT_A_ATE];
          st_d.ie = reg_wdata_i[`ADCT_A_IE];
          st_d.presc = reg_wdata_i[2:0];
          if (reg_wdata_i[`ADCT_A_FLAG]) begin
            st_d.flag = 1'b0;
          end
        end
        `ADCT_OFS_CTLB: begin
          st_d.comparator_mux_enable = reg_wdata_i[`ADCT_B_COMPARATOR_MUX_ENABLE];
          st_d.tsel = adct_tsel_t'(reg_wdata_i[2:0]);
        end
        `ADCT_OFS_MUXS: begin
          st_d.left = reg_wdata_i[`ADCT_M_LEFT];
          st_d.mux = reg_wdata_i[3:0];
        end
        `ADCT_OFS_DIDR: st_d.didr = reg_wdata_i;
        default: ;
      endcase
    end

    if (irq_ack_i) begin
      st_d.flag = 1'b0;
    end

    if (rd_lo) begin
      st_d.lock = 1'b1;
    end else if (rd_hi) begin
      st_d.lock = 1'b0;
    end

    unique case (st_q.cst)
      ADCT_OFF: begin
        // start written together with enable is honoured, long first run
        if (st_d.en && sw_start) begin
          st_d.cst = ADCT_RUN;
          st_d.cnt = '0;
        end else if (st_d.en) begin
          st_d.cst = ADCT_IDLE;
        end
      end
      ADCT_IDLE: begin
        if (!st_d.en) begin
          st_d.cst = ADCT_OFF;
        end else if (sw_start || auto_edge) begin
          st_d.cst = ADCT_RUN;
          st_d.cnt = '0;
        end
      end
      ADCT_RUN: begin
        if (!st_d.en) begin
          st_d.cst = ADCT_OFF;
        end else if (conv_fin) begin
          st_d.first = 1'b0;
          st_d.sample = 1'b1;
          st_d.flag = 1'b1;
          if (!st_q.lock && !rd_lo) begin
            st_d.result = conv_data_i;
          end
          if (st_q.ate && st_q.tsel == ADCT_TS_FREE) begin
            st_d.cnt = '0;
          end else begin
            st_d.cst = ADCT_IDLE;
          end
        end else if (ck.tick) begin
          st_d.cnt = st_q.cnt + 5'h01;
        end
      end
    endcase

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADCT_OFS_RESL: st_d.rdata = fmt_res(st_q.result, st_q.left, 1'b0);
        `ADCT_OFS_RESH: st_d.rdata = fmt_res(st_q.result, st_q.left, 1'b1);
        `ADCT_OFS_CTLA: st_d.rdata = {st_q.en, st_q.cst == ADCT_RUN,
                                      st_q.ate, st_q.flag, st_q.ie,
                                      st_q.presc};
        `ADCT_OFS_CTLB: st_d.rdata = {1'b0, st_q.comparator_mux_enable, 3'h0, st_q.tsel};
        `ADCT_OFS_MUXS: st_d.rdata = {2'h0, st_q.left, 1'b0, st_q.mux};
        `ADCT_OFS_DIDR: st_d.rdata = st_q.didr;
        default: st_d.rdata = `ADCT_RST_BYTE;
      endcase
    end

    st_d.irq = st_d.flag && st_d.ie && glob_irq_en_i;
    st_d.comp_mux = st_d.comparator_mux_enable && !st_d.en;
    st_d.pin = port_pin_i & ~st_d.didr;
    st_d.busy = st_d.cst == ADCT_RUN;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign conv_irq_o = st_q.irq;
  assign conv_enable_o = st_q.en;
  assign conv_busy_o = st_q.busy;
  assign conv_sample_o = st_q.sample;
  assign chan_sel_o = st_q.mux;
  assign comp_mux_sel_o = st_q.comp_mux;
  assign pin_buf_off_o = st_q.didr;
  assign port_pin_o = st_q.pin;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_done_set: assert property (conv_fin |=> st_q.flag && st_q.sample)
    else $error("flag not set after conversion end");
  a_irq_gate: assert property (conv_irq_o |->
    st_q.flag && st_q.ie && $past(glob_irq_en_i))
    else $error("irq raised without flag and enable");
  a_ack_clear: assert property (irq_ack_i && !conv_fin |=> !st_q.flag)
    else $error("vector entry did not clear flag");
  a_flag_keep: assert property (st_q.flag && wr_a && !irq_ack_i &&
    !reg_wdata_i[`ADCT_A_FLAG] |=> st_q.flag)
    else $error("writing zero cleared the flag");
  a_lock_hold: assert property (st_q.lock && !rd_hi |=>
    $stable(st_q.result))
    else $error("result changed while locked");
  a_left_fmt: assert property (rd_hi && st_q.left |=>
    reg_rdata_o == $past(st_q.result[9:2]))
    else $error("left adjusted high byte wrong");
  a_right_fmt: assert property (rd_hi && !st_q.left |=>
    reg_rdata_o[7:2] == 6'h00)
    else $error("unused high bits not zero");
  a_abort_run: assert property (conv_busy_o && wr_a &&
    !reg_wdata_i[`ADCT_A_EN] |=> !conv_busy_o && !conv_sample_o)
    else $error("disable did not abort conversion");
  a_no_auto: assert property (st_q.cst == ADCT_IDLE && !st_q.ate &&
    !sw_start |=> !conv_busy_o)
    else $error("conversion began without trigger");
  a_conv_len: assert property (conv_fin |-> st_q.cnt ==
    (st_q.first ? 5'(FIRST_CYC - 1) : 5'(NORM_CYC - 1)))
    else $error("conversion length wrong");
  a_comp_sel: assert property (comp_mux_sel_o |-> conv_enable_o == 1'b0)
    else $error("mux drives comparator while converter on");
  a_pin_mask: assert property ((port_pin_o & pin_buf_off_o) == 8'h00)
    else $error("disabled pin reads one");

  c_conv_done: cover property (conv_fin ##1 conv_irq_o);
  c_auto_start: cover property (st_q.cst == ADCT_IDLE && auto_edge &&
    !sw_start ##1 conv_busy_o);
  c_free_run: cover property (conv_fin && conv_busy_o ##1 conv_busy_o);
  c_locked_drop: cover property (conv_fin && st_q.lock);

endmodule
`default_nettype wire

/* File: tb/adct_conv_model.sv */
// behavioural converter core seen from the control block
// assumes the control block samples the data only while busy
`timescale 1ns/100ps
`default_nettype none
module adct_conv_model (
  input wire logic clk_sys_i,
  input wire logic busy_i,
  input wire logic [9:0] val_i,
  output logic [9:0] data_o
);
  logic [9:0] hold_q;
  // idle lines toggle so a stray sample cannot pass unseen
  always_ff @(posedge clk_sys_i) begin
    hold_q <= busy_i ? val_i : ~hold_q;
  end
  assign data_o = hold_q;
endmodule
`default_nettype wire

/* File: tb/adc_control_result_trigger_test.sv */
// self-checking bench for the converter control block
// assumes adct_core with shortened conversion counts and a core model
`timescale 1ns/100ps
`default_nettype none
`include "adct_regs.svh"
module adc_control_result_trigger_test;
  localparam int NC = 3;
  localparam int FC = 5;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [7:1] trg = 7'h00;
  logic gie = 1'h0;
  logic ack = 1'h0;
  logic [9:0] val = 10'h2b7;
  logic [7:0] pin = 8'hff;
  logic [9:0] cdat;
  logic [7:0] rdat, boff, pout, d;
  logic irq, en, busy, smp, mux;
  logic [3:0] ch;
  logic [7:0] ra [7] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f};
  int err_count = 0;
  int check_count = 0;
  int n;

  adct_core #(.NORM_CYC(NC), .FIRST_CYC(FC)) DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .trig_flags_i(trg), .glob_irq_en_i(gie),
    .irq_ack_i(ack), .conv_data_i(cdat), .port_pin_i(pin),
    .conv_irq_o(irq), .conv_enable_o(en), .conv_busy_o(busy),
    .conv_sample_o(smp), .chan_sel_o(ch), .comp_mux_sel_o(mux),
    .pin_buf_off_o(boff), .port_pin_o(pout));

  adct_conv_model CM (.clk_sys_i(clk_sys_i), .busy_i(busy), .val_i(val),
    .data_o(cdat));

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_sim;
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wd <= v;
    wr <= 1'h1;
    @(posedge clk_sys_i);
    wr <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_sys_i);
    rd <= 1'h0;
    #1 v = rdat;
  endtask

  // cv without start bit: conversion comes from an auto trigger
  task automatic conv(input logic [7:0] cv, input int cyc);
    int k;
    int dv;
    k = 0;
    dv = (cv[2:0] < 3'h2) ? 2 : (1 << cv[2:0]);
    if (cv[6]) begin
      wrr(`ADCT_OFS_CTLA, cv);
    end
    while (busy !== 1'h1 && k < 9) begin
      tick(1);
      k++;
    end
    k = 0;
    while (busy === 1'h1 && k < 2000) begin
      tick(1);
      k++;
    end
    chk("conv_len", 8'h01, {7'h00, k >= (cyc-1)*dv && k <= (cyc+1)*dv});
    chk("sample", 8'h01, {7'h00, smp});
  endtask

  initial begin
    #100000;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    wrr(8'h7f, 8'hff);
    foreach (ra[i]) begin
      rdr(ra[i], d);
      chk("reset", 8'h00, d);
    end
    wrr(`ADCT_OFS_CTLB, 8'h40);
    wrr(`ADCT_OFS_DIDR, 8'ha5);
    tick(2);
    chk("mux_off", 8'h01, {7'h00, mux});
    chk("pins", 8'h5a, pout);
    chk("buf_off", 8'ha5, boff);
    pin <= 8'h3c;
    tick(2);
    chk("pins_2", 8'h18, pout);
    wrr(`ADCT_OFS_CTLA, 8'h81);
    tick(2);
    chk("mux_on", 8'h00, {7'h00, mux});
    gie <= 1'h1;
    conv(8'hc9, FC);
    chk("irq", 8'h01, {7'h00, irq});
    rdr(`ADCT_OFS_RESL, d);
    chk("res_l", 8'hb7, d);
    rdr(`ADCT_OFS_RESH, d);
    chk("res_h", 8'h02, d);
    wrr(`ADCT_OFS_CTLA, 8'h89);
    rdr(`ADCT_OFS_CTLA, d);
    chk("flag_keep", 8'h99, d);
    wrr(`ADCT_OFS_CTLA, 8'h99);
    rdr(`ADCT_OFS_CTLA, d);
    chk("flag_w1c", 8'h89, d);
    chk("irq_w1c", 8'h00, {7'h00, irq});
    conv(8'hc9, NC);
    gie <= 1'h0;
    tick(2);
    chk("irq_gie", 8'h00, {7'h00, irq});
    gie <= 1'h1;
    tick(2);
    chk("irq_set", 8'h01, {7'h00, irq});
    @(posedge clk_sys_i);
    ack <= 1'h1;
    @(posedge clk_sys_i);
    ack <= 1'h0;
    tick(2);
    chk("irq_ack", 8'h00, {7'h00, irq});
    rdr(`ADCT_OFS_CTLA, d);
    chk("flag_ack", 8'h89, d);
    // low byte first, so the held pair stays coherent
    rdr(`ADCT_OFS_RESL, d);
    val <= 10'h1c6;
    conv(8'hc9, NC);
    rdr(`ADCT_OFS_RESH, d);
    chk("lock_h", 8'h02, d);
    wrr(`ADCT_OFS_MUXS, 8'h25);
    tick(1);
    chk("chan", 8'h05, {4'h0, ch});
    rdr(`ADCT_OFS_RESL, d);
    chk("left_l", 8'hc0, d);
    rdr(`ADCT_OFS_RESH, d);
    chk("left_h", 8'had, d);
    conv(8'hc9, NC);
    rdr(`ADCT_OFS_RESL, d);
    chk("new_l", 8'h80, d);
    rdr(`ADCT_OFS_RESH, d);
    chk("new_h", 8'h71, d);
    rdr(`ADCT_OFS_CTLA, d);
    chk("start_0", 8'h00, d & 8'h40);
    for (int p = 0; p < 8; p++) begin
      conv(8'hc8 | 8'(p), NC);
    end
    wrr(`ADCT_OFS_CTLB, 8'h02);
    wrr(`ADCT_OFS_CTLA, 8'h99);
    trg[2] <= 1'h1;
    tick(6);
    chk("no_auto", 8'h00, {7'h00, busy});
    trg[2] <= 1'h0;
    for (int s = 1; s < 8; s++) begin
      wrr(`ADCT_OFS_CTLB, 8'(s));
      wrr(`ADCT_OFS_CTLA, 8'hb9);
      trg[s] <= 1'h1;
      conv(8'h01, NC);
      trg[s] <= 1'h0;
    end
    wrr(`ADCT_OFS_CTLB, 8'h01);
    trg[3] <= 1'h1;
    tick(3);
    wrr(`ADCT_OFS_CTLB, 8'h03);
    conv(8'h01, NC);
    trg[3] <= 1'h0;
    wrr(`ADCT_OFS_CTLB, 8'h00);
    tick(6);
    chk("free_sw", 8'h00, {7'h00, busy});
    wrr(`ADCT_OFS_CTLA, 8'he9);
    n = 0;
    while (smp !== 1'h1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("free_run", 8'h01, {7'h00, busy});
    rdr(`ADCT_OFS_CTLA, d);
    chk("start_1", 8'h40, d & 8'h40);
    wrr(`ADCT_OFS_CTLA, 8'h00);
    tick(1);
    chk("abort", 8'h00, {6'h00, busy, en});
    // enable and start in one write gives the long first run
    conv(8'hc9, FC);
    end_sim();
  end
endmodule
`default_nettype wire
